// ===== bench/ccu_core_model.sv
// Register file and branch side model facing the compare unit
`timescale 1ns/1ps
module ccu_core_model
  import ccu_pkg::*;
(
  input  wire logic [CCU_RF_IDX_W-1:0] rf_sel_a,
  input  wire logic [CCU_RF_IDX_W-1:0] rf_sel_b,
  input  wire logic                    condition_flag,
  output logic [CCU_DATA_W-1:0]        rf_data_a,
  output logic [CCU_DATA_W-1:0]        rf_data_b,
  output logic                         branch_taken
);
  logic [CCU_DATA_W-1:0] regs [16];

  // Known contents so no unknown reaches the subtractor
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h0000_0000;
    end
  end

  // Combinational read in the same cycle as the select
  assign rf_data_a = regs[rf_sel_a];
  assign rf_data_b = regs[rf_sel_b];
  // Branch reads the stored flag, never an older copy
  assign branch_taken = condition_flag;
endmodule

// ===== bench/compare_condition_unit_test.sv
// Self-checking bench for the compare condition unit
`timescale 1ns/1ps
module compare_condition_unit_test;
  import ccu_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic        issue_parallel = 1'b0;
  logic [3:0]  rf_sel_a, rf_sel_b, reg_addr = 4'h0;
  logic [31:0] rf_data_a, rf_data_b, reg_wdata = 32'h0000_0000;
  logic [39:0] acc0 = 40'h00_0000_0000, acc1 = 40'h00_0000_0000;
  logic        cond, zf, nf, cf, done, rej, br;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic [11:0] exp_st = 12'h000;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0;

  ccu_top dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .issue_parallel(issue_parallel),
    .rf_sel_a(rf_sel_a), .rf_sel_b(rf_sel_b), .rf_data_a(rf_data_a),
    .rf_data_b(rf_data_b), .accumulator_zero(acc0),
    .accumulator_one(acc1), .condition_flag(cond), .zero_flag(zf),
    .negative_flag(nf), .carry_flag(cf), .cmp_done_q(done),
    .cmp_reject_q(rej), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  ccu_core_model rf (.rf_sel_a(rf_sel_a), .rf_sel_b(rf_sel_b),
    .condition_flag(cond), .rf_data_a(rf_data_a),
    .rf_data_b(rf_data_b), .branch_taken(br));

  // Clock and hang guard; the run needs well under 400 cycles
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp, "register read");
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  function automatic logic [15:0] enc(logic [1:0] c, logic [1:0] t,
    logic u, logic i, logic [2:0] a, logic [2:0] b);
    return {CCU_PREFIX, c, t, u, i, 1'b0, a, b};
  endfunction

  // Flags of first minus second: {carry, neg, zero, cond}
  function automatic logic [3:0] exp_f(logic [39:0] a, logic [39:0] b,
    logic [1:0] t, logic u, logic wide);
    logic [40:0] d;
    logic        z, n, c, cc;
    d = {1'b0, a} - {1'b0, b};
    z = wide ? (d[39:0] == 40'h0) : (d[31:0] == 32'h0);
    n = wide ? d[39] : d[31];
    c = ~d[40];
    cc = (t == 2'h0) ? z : (t == 2'h1) ? (u ? ~c : n) : (u ? ~c | z : n | z);
    return {c, n, z, cc};
  endfunction

  // One accepted compare; operands land where the word selects them
  task automatic cmp(logic [15:0] w, logic [39:0] va, logic [39:0] vb);
    logic [39:0] b;
    logic [3:0]  f;
    b = w[12] ? vb : {8'h00, vb[31:0]};
    if (w[7]) b = {8'h00, {29{w[2] & ~w[8]}}, w[2:0]};
    f = exp_f(w[12] ? va : {8'h00, va[31:0]}, b, w[10:9], w[8], w[12]);
    @(posedge clk_sys);
    rf.regs[{w[11], w[5:3]}] <= va[31:0];
    if (!w[7]) rf.regs[{w[11], w[2:0]}] <= vb[31:0];
    acc0 <= va;
    acc1 <= vb;
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    if (w[11]) exp_st[0] = f[0];
    else exp_st[3:0] = f;
    chk({31'h0, done}, 32'h1, "compare done");
    chk({28'h0, cf, nf, zf, cond}, {28'h0, exp_st[3:0]}, "flags");
    chk({31'h0, br}, {31'h0, exp_st[0]}, "branch flag");
  endtask

  // A refused word: reject pulse, no flag moves
  task automatic refuse(logic [15:0] w, logic par);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    issue_parallel <= par;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    issue_parallel <= 1'b0;
    #1;
    chk({30'h0, rej, done}, 32'h2, "refusal pulse");
    chk({28'h0, cf, nf, zf, cond}, {28'h0, exp_st[3:0]}, "flags kept");
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(CCU_ADDR_STATUS, 32'h0);
    rd(4'h5, 32'h0);
    wr(CCU_ADDR_STATUS, 32'hFFFF_FA50);
    exp_st = 12'hA50;
    wr(4'h3, 32'h0000_0FFF);
    rd(CCU_ADDR_STATUS, 32'h0000_0A50);
    $display("test register access done");
    cmp(enc(2'h0, 2'h1, 1'b0, 1'b0, 3'h0, 3'h3), 40'h8FFFFFFF, 40'h1);
    cmp(enc(2'h0, 2'h1, 1'b1, 1'b0, 3'h0, 3'h3), 40'h8FFFFFFF, 40'h1);
    cmp(enc(2'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h5), 40'h1234, 40'h1234);
    cmp(enc(2'h0, 2'h2, 1'b0, 1'b0, 3'h4, 3'h1), 40'h7, 40'h80000000);
    cmp(enc(2'h0, 2'h2, 1'b1, 1'b0, 3'h4, 3'h1),
      40'h7, 40'h80000000);
    cmp(enc(2'h0, 2'h0, 1'b0, 1'b1, 3'h1, 3'h4), 40'hFFFFFFFC, 40'h0);
    cmp(enc(2'h0, 2'h1, 1'b0, 1'b1, 3'h6, 3'h3), 40'h2, 40'h0);
    cmp(enc(2'h0, 2'h2, 1'b1, 1'b1, 3'h7, 3'h7), 40'h7, 40'h0);
    cmp(enc(2'h0, 2'h1, 1'b1, 1'b1, 3'h7, 3'h7), 40'h8, 40'h0);
    $display("test data compares done");
    cmp(enc(2'h1, 2'h1, 1'b0, 1'b0, 3'h6, 3'h7), 40'hFFFFFF00, 40'h1);
    cmp(enc(2'h1, 2'h1, 1'b1, 1'b0, 3'h6, 3'h7), 40'hFFFFFF00, 40'h1);
    cmp(enc(2'h1, 2'h0, 1'b0, 1'b1, 3'h5, 3'h4), 40'hFFFFFFFC, 40'h0);
    cmp(enc(2'h1, 2'h1, 1'b1, 1'b1, 3'h3, 3'h4), 40'h5, 40'h0);
    $display("test pointer compares done");
    cmp(enc(2'h2, 2'h1, 1'b0, 1'b0, 3'h0, 3'h0),
      40'hFF_FFFF_FFFF, 40'h1);
    cmp(enc(2'h2, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0),
      40'h12_0000_0000, 40'h12_0000_0000);
    cmp(enc(2'h2, 2'h2, 1'b0, 1'b0, 3'h0, 3'h0),
      40'h01_0000_0000, 40'hFF_FFFF_FFFF);
    $display("test accumulator compares done");
    refuse(enc(2'h0, 2'h1, 1'b0, 1'b0, 3'h0, 3'h1), 1'b1);
    refuse(enc(2'h0, 2'h0, 1'b1, 1'b0, 3'h0, 3'h1), 1'b0);
    refuse(enc(2'h2, 2'h1, 1'b1, 1'b0, 3'h0, 3'h0), 1'b0);
    refuse(enc(2'h2, 2'h2, 1'b0, 1'b1, 3'h0, 3'h0), 1'b0);
    refuse(16'h4000 ^ enc(2'h0, 2'h1, 1'b0, 1'b0, 3'h0, 3'h1), 1'b0);
    refuse(16'h0040 | enc(2'h0, 2'h1, 1'b0, 1'b0, 3'h0, 3'h1), 1'b0);
    rd(CCU_ADDR_STATUS, {20'h0, exp_st});
    $display("test refusals done");
    stop_test();
  end
endmodule

// ===== src/ccu_decode.sv
// Decoder for the 16-bit compare instruction word
`timescale 1ns/1ps
module ccu_decode
  import ccu_pkg::*;
(
  input  wire logic [CCU_INSTR_W-1:0]  instr,
  output logic                         legal,
  output ccu_cls_t                     cls,
  output ccu_test_t                    test,
  output logic                         unsgn,
  output logic                         use_imm,
  output logic [CCU_RF_IDX_W-1:0]      sel_a,
  output logic [CCU_RF_IDX_W-1:0]      sel_b,
  output logic [CCU_DATA_W-1:0]        imm_ext
);

  logic                 pfx_ok;
  logic [CCU_IDX_W-1:0] idx_a;
  logic [CCU_IDX_W-1:0] idx_b;
  logic                 imm_sign;
  logic [CCU_RF_IDX_W-1:0] base;

  // Field extraction; one 16-bit word carries every compare form
  assign pfx_ok  = instr[CCU_PFX_HI:CCU_PFX_LO] == CCU_PREFIX; // RULE13
  assign cls     = ccu_cls_t'(instr[CCU_CLS_HI:CCU_CLS_LO]);
  assign test    = ccu_test_t'(instr[CCU_TST_HI:CCU_TST_LO]);
  assign unsgn   = instr[CCU_UNS_BIT];
  assign use_imm = instr[CCU_IMM_BIT];
  assign idx_a   = instr[CCU_OPA_HI:CCU_OPA_LO];
  assign idx_b   = instr[CCU_OPB_HI:CCU_OPB_LO];

  // Pointer slots 6 and 7 are the stack and frame pointers
  assign base  = (cls == CCU_CLS_PTR) ? CCU_PTR_BASE : CCU_DATA_BASE;
  assign sel_a = base | {1'b0, idx_a}; // RULE2 RULE8
  assign sel_b = base | {1'b0, idx_b}; // RULE2 RULE8

  // Small constant: sign-extended unless the unsigned option is set
  assign imm_sign = ~unsgn & idx_b[CCU_IMM_W-1]; // RULE4
  assign imm_ext  = {{(CCU_DATA_W-CCU_IMM_W){imm_sign}}, idx_b}; // RULE5

  // Forms outside the compare set are not decoded; privilege is not checked
  assign legal = pfx_ok
               & (cls != CCU_CLS_RSV)
               & (test != CCU_TST_RSV)
               & ~instr[CCU_RSV_BIT]
               & ~(unsgn & (test == CCU_TST_EQ)) // RULE15
               & ~((cls == CCU_CLS_ACC) & (unsgn | use_imm)); // RULE10

endmodule

// ===== src/ccu_flags.sv
// Subtractor and condition evaluation for one operand width
`timescale 1ns/1ps
module ccu_flags
  import ccu_pkg::*;
#(
  parameter int W = CCU_DATA_W
) (
  input  wire logic [W-1:0]  op_a,
  input  wire logic [W-1:0]  op_b,
  input  wire ccu_test_t     test,
  input  wire logic          unsgn,
  output logic               zero,
  output logic               neg,
  output logic               carry,
  output logic               cond
);

  logic [W:0] diff;

  // First minus second as a plus not-b plus one; carry out means no borrow
  assign diff  = {1'b0, op_a} + {1'b0, ~op_b} + {{W{1'b0}}, 1'b1}; // RULE3
  assign carry = diff[W]; // RULE16
  assign neg   = diff[W-1];
  assign zero  = (diff[W-1:0] == '0);

  // Difference itself goes nowhere; only the flags leave this module
  always_comb begin
    cond = 1'b0;
    case (test)
      CCU_TST_EQ: begin
        cond = zero; // RULE6
      end
      CCU_TST_LT: begin
        cond = unsgn ? ~carry : neg; // RULE6
      end
      CCU_TST_LE: begin
        cond = unsgn ? (~carry | zero) : (neg | zero); // RULE6
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

endmodule

// ===== src/ccu_pkg.sv
// Constants, field layout and types shared by the compare condition unit
package ccu_pkg;

  // Datapath widths
  localparam int CCU_DATA_W   = 32;
  localparam int CCU_ACC_W    = 40;
  localparam int CCU_IMM_W    = 3;
  localparam int CCU_IDX_W    = 3;
  localparam int CCU_RF_IDX_W = 4;

  // Compare instruction word layout
  localparam int         CCU_INSTR_W  = 16;
  localparam int         CCU_PFX_HI   = 15;
  localparam int         CCU_PFX_LO   = 13;
  localparam logic [2:0] CCU_PREFIX   = 3'h5;
  localparam int         CCU_CLS_HI   = 12;
  localparam int         CCU_CLS_LO   = 11;
  localparam int         CCU_TST_HI   = 10;
  localparam int         CCU_TST_LO   = 9;
  localparam int         CCU_UNS_BIT  = 8;
  localparam int         CCU_IMM_BIT  = 7;
  localparam int         CCU_RSV_BIT  = 6;
  localparam int         CCU_OPA_HI   = 5;
  localparam int         CCU_OPA_LO   = 3;
  localparam int         CCU_OPB_HI   = 2;
  localparam int         CCU_OPB_LO   = 0;

  // Register file index spaces: data registers first, pointers above
  localparam logic [CCU_RF_IDX_W-1:0] CCU_DATA_BASE = 4'h0;
  localparam logic [CCU_RF_IDX_W-1:0] CCU_PTR_BASE  = 4'h8;

  // Operand classes and tests
  typedef enum logic [1:0] {
    CCU_CLS_DATA = 2'h0,
    CCU_CLS_PTR  = 2'h1,
    CCU_CLS_ACC  = 2'h2,
    CCU_CLS_RSV  = 2'h3
  } ccu_cls_t;

  typedef enum logic [1:0] {
    CCU_TST_EQ  = 2'h0,
    CCU_TST_LT  = 2'h1,
    CCU_TST_LE  = 2'h2,
    CCU_TST_RSV = 2'h3
  } ccu_test_t;

  // Arithmetic status register layout
  localparam int CCU_ST_W        = 12;
  localparam int CCU_ST_CC       = 0;
  localparam int CCU_ST_ZERO     = 1;
  localparam int CCU_ST_NEG      = 2;
  localparam int CCU_ST_CARRY    = 3;
  localparam int CCU_ST_OTHER_LO = 4;
  localparam int CCU_ST_OTHER_HI = 11;
  localparam logic [CCU_ST_W-1:0] CCU_ST_RST = 12'h000;

  // Register port
  localparam int                CCU_ADDR_W    = 4;
  localparam int                CCU_REG_W     = 32;
  localparam logic [CCU_ADDR_W-1:0] CCU_ADDR_STATUS = 4'h0;

endpackage

// ===== src/ccu_top.sv
// Compare condition unit: decode, compare datapath and arithmetic status
//
// Behaviour
// (RULE1) Condition flag is a status register bit; every compare writes it.
// (RULE2) Data compares read data registers; signed 32-bit unless unsigned.
// (RULE3) Compares subtract second from first; difference is dropped.
// (RULE4) Signed small constant ranges -4 to 3 and is sign-extended.
// (RULE5) Unsigned small constant ranges 0 to 7 and is zero-extended.
// (RULE6) Equal is zero; less is negative, or carry clear when unsigned.
// (RULE7) Data compares set condition, zero, negative, carry; others kept.
// (RULE8) Pointer compares use pointers, stack and frame; only condition moves.
// (RULE9) Accumulator compares are 40-bit signed: equal, less, less-or-equal.
// (RULE10) No unsigned or constant form exists for accumulator compares.
// (RULE11) Accumulator compares set condition, zero, negative and carry.
// (RULE12) Branch logic reads the condition flag the last compare wrote.
// (RULE13) Compares are 16-bit words, run in user and supervisor mode.
// (RULE14) A compare offered inside a parallel bundle is refused.
// (RULE15) Equality exists only signed; unsigned equality is not decoded.
// (RULE16) Carry means no borrow; unsigned first-below-second clears carry.
`timescale 1ns/1ps
module ccu_top
  import ccu_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    instr_valid,
  input  wire logic [CCU_INSTR_W-1:0]  instr_word,
  input  wire logic                    issue_parallel,
  output logic [CCU_RF_IDX_W-1:0]      rf_sel_a,
  output logic [CCU_RF_IDX_W-1:0]      rf_sel_b,
  input  wire logic [CCU_DATA_W-1:0]   rf_data_a,
  input  wire logic [CCU_DATA_W-1:0]   rf_data_b,
  input  wire logic [CCU_ACC_W-1:0]    accumulator_zero,
  input  wire logic [CCU_ACC_W-1:0]    accumulator_one,
  output logic                         condition_flag,
  output logic                         zero_flag,
  output logic                         negative_flag,
  output logic                         carry_flag,
  output logic                         cmp_done_q,
  output logic                         cmp_reject_q,
  input  wire logic [CCU_ADDR_W-1:0]   reg_addr,
  input  wire logic [CCU_REG_W-1:0]    reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [CCU_REG_W-1:0]         reg_rdata_q
);

  logic                     dec_legal;
  ccu_cls_t                 dec_cls;
  ccu_test_t                dec_test;
  logic                     dec_unsgn;
  logic                     dec_imm;
  logic [CCU_DATA_W-1:0]    dec_imm_ext;
  logic [CCU_DATA_W-1:0]    op_b;
  logic                     d_zero;
  logic                     d_neg;
  logic                     d_carry;
  logic                     d_cond;
  logic                     a_zero;
  logic                     a_neg;
  logic                     a_carry;
  logic                     a_cond;
  logic                     accept;
  logic                     status_hit;
  logic [CCU_ST_W-1:0]      arith_status_reg_q;

  // Instruction word decode
  ccu_decode u_decode (
    .instr   (instr_word),
    .legal   (dec_legal),
    .cls     (dec_cls),
    .test    (dec_test),
    .unsgn   (dec_unsgn),
    .use_imm (dec_imm),
    .sel_a   (rf_sel_a),
    .sel_b   (rf_sel_b),
    .imm_ext (dec_imm_ext)
  );

  // Second operand: register or extended small constant
  assign op_b = dec_imm ? dec_imm_ext : rf_data_b; // RULE4 RULE5

  // 32-bit path shared by data and pointer compares
  ccu_flags #(
    .W (CCU_DATA_W)
  ) u_flags_word (
    .op_a  (rf_data_a),
    .op_b  (op_b),
    .test  (dec_test),
    .unsgn (dec_unsgn),
    .zero  (d_zero),
    .neg   (d_neg),
    .carry (d_carry),
    .cond  (d_cond)
  );

  // 40-bit accumulator path, always signed
  ccu_flags #(
    .W (CCU_ACC_W)
  ) u_flags_acc (
    .op_a  (accumulator_zero), // RULE9
    .op_b  (accumulator_one),
    .test  (dec_test),
    .unsgn (1'b0),
    .zero  (a_zero),
    .neg   (a_neg),
    .carry (a_carry),
    .cond  (a_cond)
  );

  // Compares issue alone; a bundled or undecodable word is refused
  assign accept     = instr_valid & dec_legal & ~issue_parallel; // RULE14
  assign status_hit = reg_addr == CCU_ADDR_STATUS;

  // Status update; a compare in the same cycle as a write wins on its bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arith_status_reg_q <= CCU_ST_RST;
    end else begin
      if (reg_wr && status_hit) begin
        arith_status_reg_q <= reg_wdata[CCU_ST_W-1:0];
      end
      if (accept) begin
        case (dec_cls)
          CCU_CLS_DATA: begin
            arith_status_reg_q[CCU_ST_CC]    <= d_cond; // RULE1 RULE7
            arith_status_reg_q[CCU_ST_ZERO]  <= d_zero; // RULE7
            arith_status_reg_q[CCU_ST_NEG]   <= d_neg; // RULE7
            arith_status_reg_q[CCU_ST_CARRY] <= d_carry; // RULE7
          end
          CCU_CLS_PTR: begin
            arith_status_reg_q[CCU_ST_CC]    <= d_cond; // RULE1 RULE8
          end
          CCU_CLS_ACC: begin
            arith_status_reg_q[CCU_ST_CC]    <= a_cond; // RULE1 RULE11
            arith_status_reg_q[CCU_ST_ZERO]  <= a_zero; // RULE11
            arith_status_reg_q[CCU_ST_NEG]   <= a_neg; // RULE11
            arith_status_reg_q[CCU_ST_CARRY] <= a_carry; // RULE11
          end
          default: begin
            arith_status_reg_q <= arith_status_reg_q;
          end
        endcase
      end
    end
  end

  // Flags straight from the register so branches see the stored value
  assign condition_flag = arith_status_reg_q[CCU_ST_CC]; // RULE12
  assign zero_flag      = arith_status_reg_q[CCU_ST_ZERO];
  assign negative_flag  = arith_status_reg_q[CCU_ST_NEG];
  assign carry_flag     = arith_status_reg_q[CCU_ST_CARRY];

  // One-cycle completion and refusal pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_done_q   <= 1'b0;
      cmp_reject_q <= 1'b0;
    end else begin
      cmp_done_q   <= accept;
      cmp_reject_q <= instr_valid & ~accept; // RULE14
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd && status_hit) begin
      reg_rdata_q <= {{(CCU_REG_W-CCU_ST_W){1'b0}}, arith_status_reg_q};
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // Checks on the compare datapath and status register

  a_data_flags: assert property ( // RULE7
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_DATA |=>
      zero_flag == $past(d_zero) && negative_flag == $past(d_neg)
      && carry_flag == $past(d_carry) && condition_flag == $past(d_cond))
    else $error("data compare flags not taken from subtraction");

  a_ptr_keeps_flags: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_PTR && !reg_wr |=>
      $stable(zero_flag) && $stable(negative_flag) && $stable(carry_flag)
      && $stable(arith_status_reg_q[CCU_ST_OTHER_HI:CCU_ST_OTHER_LO]))
    else $error("pointer compare disturbed status flags");

  a_acc_signed_lt: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_ACC && dec_test == CCU_TST_LT |=>
      condition_flag == $past(a_neg) && carry_flag == $past(a_carry))
    else $error("accumulator less-than flag wrong");

  a_uns_below: assert property ( // RULE16
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_DATA && dec_unsgn
      && dec_test == CCU_TST_LT |=>
      condition_flag == ($past(rf_data_a) < $past(op_b)))
    else $error("unsigned below does not match carry clear");

  a_signed_const: assert property ( // RULE4
    @(posedge clk_sys) disable iff (rst)
    accept && dec_imm && !dec_unsgn |->
      $signed(op_b) >= -4 && $signed(op_b) <= 3
      && op_b[CCU_IMM_W-1:0] == instr_word[CCU_OPB_HI:CCU_OPB_LO])
    else $error("signed small constant not sign-extended");

  a_unsigned_const: assert property ( // RULE5
    @(posedge clk_sys) disable iff (rst)
    accept && dec_imm && dec_unsgn |-> op_b <= 7
      && op_b[CCU_IMM_W-1:0] == instr_word[CCU_OPB_HI:CCU_OPB_LO])
    else $error("unsigned small constant not zero-extended");

  a_bundle_refused: assert property ( // RULE14
    @(posedge clk_sys) disable iff (rst)
    instr_valid && issue_parallel && !reg_wr |=>
      cmp_reject_q && !cmp_done_q && $stable(arith_status_reg_q))
    else $error("bundled compare was executed");

  a_illegal_forms: assert property ( // RULE10
    @(posedge clk_sys) disable iff (rst)
    (dec_cls == CCU_CLS_ACC && (dec_unsgn || dec_imm))
      || (dec_unsgn && dec_test == CCU_TST_EQ) |-> !dec_legal)
    else $error("forbidden compare form decoded");

  a_branch_sees_cc: assert property ( // RULE12
    @(posedge clk_sys) disable iff (rst)
    accept ##1 (!accept && !reg_wr) [*2] |->
      condition_flag == $past(condition_flag, 1))
    else $error("condition flag changed without a compare");

  a_status_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && status_hit |=>
      reg_rdata_q[CCU_ST_W-1:0] == $past(arith_status_reg_q))
    else $error("status read returned wrong value");

  // Flags against the operands themselves; a_acc_le alone checks against the subtractor's outputs
  a_zero_from_diff: assert property ( // RULE3
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_DATA |=>
      zero_flag == ($past(rf_data_a) == $past(op_b)))
    else $error("zero flag does not match operand equality");

  a_carry_no_borrow: assert property ( // RULE16
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_DATA |=>
      carry_flag == ($past(rf_data_a) >= $past(op_b)))
    else $error("carry flag is not the no-borrow of the subtraction");

  a_acc_equal: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_ACC |=>
      zero_flag == ($past(accumulator_zero) == $past(accumulator_one)))
    else $error("accumulator zero flag does not match equality");

  a_acc_le: assert property ( // RULE11
    @(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_ACC && dec_test == CCU_TST_LE |=>
      condition_flag == ($past(a_neg) || $past(a_zero)))
    else $error("accumulator less-or-equal flag wrong");

  // Software-only bits survive every compare
  a_other_bits: assert property ( // RULE7
    @(posedge clk_sys) disable iff (rst)
    accept && !reg_wr |=>
      $stable(arith_status_reg_q[CCU_ST_OTHER_HI:CCU_ST_OTHER_LO]))
    else $error("compare disturbed software status bits");

  // Operand selects stay inside the bank of their class
  a_data_bank: assert property ( // RULE2
    @(posedge clk_sys) disable iff (rst)
    dec_cls == CCU_CLS_DATA |->
      rf_sel_a < CCU_PTR_BASE && rf_sel_b < CCU_PTR_BASE)
    else $error("data compare selected a pointer register");

  a_ptr_bank: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    dec_cls == CCU_CLS_PTR |->
      rf_sel_a >= CCU_PTR_BASE && rf_sel_b >= CCU_PTR_BASE)
    else $error("pointer compare selected a data register");

  // Exactly one of the two pulses follows every offered word
  a_done_pulse: assert property ( // RULE1
    @(posedge clk_sys) disable iff (rst)
    accept |=> cmp_done_q && !cmp_reject_q)
    else $error("accepted compare gave no completion pulse");

  a_reject_pulse: assert property ( // RULE15
    @(posedge clk_sys) disable iff (rst)
    instr_valid && !accept |=> cmp_reject_q && !cmp_done_q)
    else $error("refused word gave no refusal pulse");

  // Register port: write lands whole, idle read data is zero
  a_status_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_wr && status_hit && !accept |=>
      arith_status_reg_q == $past(reg_wdata[CCU_ST_W-1:0]))
    else $error("status write did not land");

  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(reg_rd && status_hit) |=> reg_rdata_q == '0)
    else $error("read data not zero outside a status read");

  // Main scenarios
  c_data_signed: cover property (@(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_DATA && !dec_unsgn ##1 condition_flag);
  c_ptr_uns_imm: cover property (@(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_PTR && dec_unsgn && dec_imm);
  c_acc_le: cover property (@(posedge clk_sys) disable iff (rst)
    accept && dec_cls == CCU_CLS_ACC && dec_test == CCU_TST_LE);
  c_refused: cover property (@(posedge clk_sys) disable iff (rst)
    cmp_reject_q);
  c_status_read: cover property (@(posedge clk_sys) disable iff (rst)
    reg_rd && status_hit ##1 reg_rdata_q != '0);

endmodule
